// File: include/slg_pkg.sv
// Package for the scan logic gate blocks
package slg_pkg;
  localparam int SLG_WIDTH = 8;
  localparam int SLG_XOR_WIDTH = 2;
  localparam logic [SLG_WIDTH-1:0] SLG_PREV_RESET = 8'h00;
  localparam logic [SLG_WIDTH-1:0] SLG_ALL_ONES = 8'hFF;
  localparam logic [SLG_WIDTH-1:0] SLG_ALL_ZEROS = 8'h00;

  typedef struct packed {
    logic [SLG_WIDTH-1:0] logic_in;
    logic [SLG_WIDTH-1:0] used;
  } slg_gate_in_t;

  typedef struct packed {
    logic conj;
    logic edge_qualified_conjunction;
    logic disj;
    logic inv;
    logic xor_out;
    logic nconj;
    logic edge_qualified_negated_conjunction;
    logic ndisj;
    logic rise_disj;
    logic fall_disj;
  } slg_outs_t;
endpackage

// File: hw/slg_gates.sv
// Ten scan-driven logic function blocks
module slg_gates
  import slg_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic scan_tick_i,
  input wire logic scan_clear_i,
  input wire slg_gate_in_t conj_i,
  input wire slg_gate_in_t eq_conj_i,
  input wire slg_gate_in_t disj_i,
  input wire logic inv_i,
  input wire logic [SLG_XOR_WIDTH-1:0] xor_i,
  input wire slg_gate_in_t nconj_i,
  input wire slg_gate_in_t eq_nconj_i,
  input wire slg_gate_in_t ndisj_i,
  input wire slg_gate_in_t rise_i,
  input wire slg_gate_in_t fall_i,
  output slg_outs_t outs_o
);

  // Neutral fill for unconnected inputs
  logic [SLG_WIDTH-1:0] conj_v;
  logic [SLG_WIDTH-1:0] eq_conj_v;
  logic [SLG_WIDTH-1:0] disj_v;
  logic [SLG_WIDTH-1:0] nconj_v;
  logic [SLG_WIDTH-1:0] eq_nconj_v;
  logic [SLG_WIDTH-1:0] ndisj_v;
  logic [SLG_WIDTH-1:0] rise_v;
  logic [SLG_WIDTH-1:0] fall_v;
  logic [SLG_WIDTH-1:0] prev_eq_conj;
  logic [SLG_WIDTH-1:0] prev_eq_nconj;
  logic [SLG_WIDTH-1:0] prev_rise;
  logic [SLG_WIDTH-1:0] prev_fall;
  slg_outs_t next_outs;

  assign conj_v = conj_i.logic_in | ~conj_i.used;
  assign eq_conj_v = eq_conj_i.logic_in | ~eq_conj_i.used;
  assign nconj_v = nconj_i.logic_in | ~nconj_i.used;
  assign eq_nconj_v = eq_nconj_i.logic_in | ~eq_nconj_i.used;
  assign disj_v = disj_i.logic_in & disj_i.used;
  assign ndisj_v = ndisj_i.logic_in & ndisj_i.used;
  assign rise_v = rise_i.logic_in & rise_i.used;
  assign fall_v = fall_i.logic_in & fall_i.used;

  // Block results in ascending block order
  always_comb begin
    next_outs.conj = (conj_v == SLG_ALL_ONES);
    next_outs.edge_qualified_conjunction = (eq_conj_v == SLG_ALL_ONES)
      && (prev_eq_conj != SLG_ALL_ONES);
    next_outs.disj = (disj_v != SLG_ALL_ZEROS);
    next_outs.inv = ~inv_i;
    next_outs.xor_out = ^xor_i;
    next_outs.nconj = (nconj_v != SLG_ALL_ONES);
    next_outs.edge_qualified_negated_conjunction = (eq_nconj_v != SLG_ALL_ONES)
      && (prev_eq_nconj == SLG_ALL_ONES);
    next_outs.ndisj = (ndisj_v == SLG_ALL_ZEROS);
    next_outs.rise_disj = |(rise_v & ~prev_rise);
    next_outs.fall_disj = |(~fall_v & prev_fall);
  end

  // Outputs update once per scan
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      outs_o <= '0;
    end else if (scan_clear_i) begin
      outs_o <= '0;
    end else if (scan_tick_i) begin
      outs_o <= next_outs;
    end
  end

  // Previous-scan input copies
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prev_eq_conj <= SLG_PREV_RESET;
      prev_eq_nconj <= SLG_PREV_RESET;
      prev_rise <= SLG_PREV_RESET;
      prev_fall <= SLG_PREV_RESET;
    end else if (scan_clear_i) begin
      prev_eq_conj <= SLG_PREV_RESET;
      prev_eq_nconj <= SLG_PREV_RESET;
      prev_rise <= SLG_PREV_RESET;
      prev_fall <= SLG_PREV_RESET;
    end else if (scan_tick_i) begin
      prev_eq_conj <= eq_conj_v;
      prev_eq_nconj <= eq_nconj_v;
      prev_rise <= rise_v;
      prev_fall <= fall_v;
    end
  end

endmodule // slg_gates

// File: tb/slg_src.sv
// Terminal model feeding the eight struct gate inputs (not inv_i or xor_i)
module slg_src import slg_pkg::*; (input wire logic [7:0] v_i, output slg_gate_in_t g_o);
  timeunit 1ns; timeprecision 1ns;
  assign g_o = {v_i, 8'hFE};
endmodule // slg_src

// File: tb/slg_gates_checker.sv
// Port checker for the scan gate blocks
module slg_chk import slg_pkg::*; (input wire logic clk_i, resetn_i, scan_tick_i,
  input wire logic scan_clear_i, inv_i, input wire logic [1:0] xor_i,
  input wire slg_gate_in_t conj_i, disj_i, input wire slg_outs_t outs_o);
  timeunit 1ns; timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  wire t = scan_tick_i & ~scan_clear_i, k = ~scan_tick_i & ~scan_clear_i;
  wire a = &(conj_i.logic_in | ~conj_i.used), o = |(disj_i.logic_in & disj_i.used);
  wire [9:0] q = outs_o;
  and_out_a: assert property (t |=> q[9] == $past(a)) else $error("and");
  or_out_a: assert property (t |=> q[7] == $past(o)) else $error("or");
  inv_out_a: assert property (t |=> q[6] != $past(inv_i)) else $error("inv");
  xor_out_a: assert property (t |=> q[5] == ^$past(xor_i)) else $error("xor");
  eq_and_once_a: assert property (q[8] && t |=> !q[8]) else $error("eqa");
  eq_nand_once_a: assert property (q[3] && t |=> !q[3]) else $error("eqn");
  out_hold_a: assert property (k |=> $stable(outs_o)) else $error("hold");
  clear_out_a: assert property (scan_clear_i |=> q == '0) else $error("clr");
  cover property (q[8]);
  cover property (q[3]);
  cover property (q[0]);
endmodule // slg_chk
bind slg_gates slg_chk u_slg_chk(.*);

// File: tb/tb_slg_gates.sv
// Random bench for the scan gate blocks
module tb_slg_gates import slg_pkg::*; ;
  timeunit 1ns; timeprecision 1ns;
  logic clk_i = 0, resetn_i = 0, h = 0;
  logic [7:0] p = 0;
  logic [15:0] v = 16'hFFFF;
  slg_gate_in_t g;
  wire [7:0] m = g.logic_in & g.used;
  wire a = &(g.logic_in | ~g.used);
  slg_outs_t o, e = '0;
  int miscompares = 0, n_tests = 0, cyc = 0;
  initial forever #20 clk_i = ~clk_i;
  slg_src u_slg_src(.v_i(v[15:8]), .g_o(g));
  slg_gates u_slg_gates(.clk_i, .resetn_i, .scan_tick_i(v[1:0] != 2'h0), .conj_i(g),
    .scan_clear_i(v[7:4] == 4'h0), .eq_conj_i(g), .disj_i(g), .inv_i(v[2]), .xor_i(v[4:3]),
    .nconj_i(g), .eq_nconj_i(g), .ndisj_i(g), .rise_i(g), .fall_i(g), .outs_o(o));
  function automatic slg_outs_t ex();
    return {a, a & ~h, |m, ~v[2], ^v[4:3], ~a, ~a & h, ~|m, |(m & ~p), |(~m & p)};
  endfunction
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic tally_and_finish(input int x);
    miscompares += x;
    if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk_i) if (++cyc > 4000) tally_and_finish(1);
  initial begin
    repeat (16) @(negedge clk_i);
    resetn_i = 1;
    for (int i = 0; i < 3000; i++) begin
      @(negedge clk_i);
      if (v[7:4] == 4'h0) {e, h, p} = '0;
      else if (v[1:0] != 2'h0) {e, h, p} = {ex(), a, m};
      n_tests++;
      miscompares += int'(o !== e);
      if (o !== e) $display("MISMATCH %0t %h", $time, o);
      // Seed, then all high, all low, clear with tick, then random
      case (i)
        0: v = 16'h0022;
        1: v = 16'hFF11;
        2: v = 16'h0011;
        3: v = 16'hFF01;
        default: v = lfsr_next(v);
      endcase
    end
    tally_and_finish(0);
  end
endmodule // tb_slg_gates
